// ### src/smc_top.sv
// Serial master control: registers, FIFOs, shifter and DMA requests
// Behaviour
// - Low-speed DMA: long bit picks byte/word push
// - Low-speed mode needs own DMA enable bit
// - Per-line select polarity, reset active low
// - Full receive FIFO stalls further serial bytes
// - Needs-reading flag at three-quarter fill, active
// - Can-accept flag while transmit FIFO has room
// - Has-data flag while receive FIFO nonempty
// - Done when complete; cleared by push or inactive
// - Mode bit picks standard or nine-bit protocol
// - Read-enable turns shared data wire around
// - Auto release of select at DMA count end
// - Interrupt while needs-reading flag and enabled
// - Interrupt while done flag and enabled
// - DMA requests only when enabled, word moves
// - Inactive: selects idle, port writes load settings
// - Active: selects driven; frame end clears active
// - Global polarity bit makes selects active high
// - One-shot FIFO clears act before frame start
// - Clock polarity sets idle clock level
// - Clock phase places first clock transition
// - Select field picks line; code three reserved
// - Clock divider, zero means 65536, even only
// - Data shifted out most significant bit first
// - Low-speed items carry ninth command/param bit
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module smc_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Register bus
  input  wire smc_pkg::smc_wb_req_t wb_i,
  output var  smc_pkg::smc_wb_rsp_t wb_o,
  // Serial pins
  input  wire logic                 miso_i,
  output var  smc_pkg::smc_pins_t   pins_o,
  // DMA engine handshake
  input  wire logic                 dma_frame_end_i,
  output logic                      tx_dreq_o,
  output logic                      rx_dreq_o,
  // Interrupt
  output logic                      irq_o
);
  import smc_pkg::*;

  smc_state_t  s;        // Registered state
  smc_state_t  n;        // Next state
  logic        active;   // Transfer active bit
  logic        low_speed_nine_bit_mode;    // Nine-bit protocol on
  logic        dma_on;   // DMA requests allowed
  logic        wide;     // Port moves whole words
  logic [2:0]  nbytes;   // Bytes per port access
  logic        rx_full_flag;      // Receive FIFO full
  logic        rx_needs_reading_flag;      // Receive FIFO needs reading
  logic        txd;      // Transmit FIFO has room
  logic        rxd;      // Receive FIFO has data
  logic        done;     // Transfer complete
  logic [15:0] half;     // Half clock period in cycles
  logic        take;     // Bus request taken this cycle
  logic [31:0] bmask;    // Byte lane mask from sel
  logic [2:0]  sel_lines; // Chip select levels

  // Mode decode
  assign active = s.csr[B_TA];
  assign low_speed_nine_bit_mode  = s.csr[B_LSM];
  assign dma_on = s.csr[B_DMA_REQUEST_ENABLE] & (~low_speed_nine_bit_mode | s.csr[B_LDMA]);
  // Word moves in DMA, or per long bit in low-speed DMA
  assign wide   = low_speed_nine_bit_mode ? (s.csr[B_LDMA] & s.csr[B_LONG])
                        : dma_on;
  assign nbytes = wide ? WORD_BYTES : 3'h1;

  // Status flags, derived from live FIFO levels
  assign rx_full_flag  = s.rx_cnt == FIFO_FULL;
  assign rx_needs_reading_flag  = active & (s.rx_cnt >= RXR_LEVEL);
  assign txd  = s.tx_cnt != FIFO_FULL;
  assign rxd  = s.rx_cnt != 5'h0;
  // Done also waits for the DMA byte count to run out
  assign done = active & ~s.busy & (s.tx_cnt == 5'h0)
              & ~(dma_on & (s.rem != 16'h0));

  // Divider: zero gives the largest divisor, odd above one rounds down
  always_comb begin
    if (s.divider_field == 16'h0) begin
      half = HALF_MAX;
    end else if (s.divider_field[15:1] == 15'h0) begin
      half = 16'h1;  // Divisor 1 cannot be halved; use 2
    end else begin
      half = {1'b0, s.divider_field[15:1]};
    end
  end

  // Bus decode
  assign take  = wb_i.cyc & wb_i.stb & ~s.ack;
  assign bmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
                  {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};

  // Next-state logic
  always_comb begin
    logic [2:0]  tpush;
    logic        tpop;
    logic        rpush;
    logic [2:0]  rpop;
    logic        clr_tx;
    logic        clr_rx;
    logic [25:0] m;
    tpush  = 3'h0;
    tpop   = 1'b0;
    rpush  = 1'b0;
    rpop   = 3'h0;
    clr_tx = 1'b0;
    clr_rx = 1'b0;
    m      = CS_RW_MASK & bmask[25:0];
    n      = s;
    n.ack  = take;
    // Only the second stage is read by logic
    n.miso_sync = {s.miso_sync[0], miso_i};

    // Register access, answered one cycle after take
    if (take) begin
      n.rdat = 32'h0;
      unique case (wb_i.adr)
        OFF_CS: begin
          if (wb_i.we) begin
            n.csr  = (s.csr & ~m) | (wb_i.dat[25:0] & m);
            clr_tx = wb_i.sel[0] & wb_i.dat[B_CLRTX];
            clr_rx = wb_i.sel[0] & wb_i.dat[B_CLRRX];
          end else begin
            n.rdat = {6'h0, s.csr[25:21], rx_full_flag, rx_needs_reading_flag, txd, rxd, done,
                      s.csr[15:6], 2'h0, s.csr[3:0]};
          end
        end
        OFF_FIFO: begin
          if (wb_i.we && active) begin
            // Whole access is dropped if it does not fit
            if ({2'h0, nbytes} <= FIFO_FULL - s.tx_cnt) begin
              tpush = nbytes;
            end
          end else if (wb_i.we) begin
            // Settings preload from a DMA block header
            n.transfer_byte_count     = wb_i.dat[31:16];
            n.csr[7:0] = wb_i.dat[7:0];
            clr_tx     = wb_i.dat[B_CLRTX];
            clr_rx     = wb_i.dat[B_CLRRX];
          end else begin
            // Missing bytes read as zero
            for (int k = 0; k < 4; k++) begin
              if (k < int'(nbytes) && k < int'(s.rx_cnt)) begin
                n.rdat[8*k +: 8] = s.rx_mem[s.rx_rd + 4'(k)];
              end
            end
            rpop = (s.rx_cnt < {2'h0, nbytes}) ? s.rx_cnt[2:0]
                                               : nbytes;
          end
        end
        OFF_CLK: begin
          if (wb_i.we) n.divider_field = wb_i.dat[15:0];
          n.rdat = {16'h0, s.divider_field};
        end
        OFF_TRANSFER_BYTE_COUNT: begin
          if (wb_i.we) n.transfer_byte_count = wb_i.dat[15:0];
          n.rdat = {16'h0, s.transfer_byte_count};
        end
        OFF_LOW_SPEED_HOLD_DELAY: begin
          if (wb_i.we) n.output_hold_delay = wb_i.dat[3:0];
          n.rdat = {28'h0, s.output_hold_delay};
        end
        OFF_DC: begin
          if (wb_i.we) n.dc = (s.dc & ~bmask) | (wb_i.dat & bmask);
          n.rdat = s.dc;
        end
        OFF_WIRE: begin
          if (wb_i.we) n.wire_shared = wb_i.dat[0];
          n.rdat = {31'h0, s.wire_shared};
        end
        default: begin
          n.rdat = 32'h0;  // Unmapped: acked, reads zero
        end
      endcase
      if (wb_i.we) n.rdat = s.rdat;
    end

    // New frame: reload count and re-arm the selects
    if (n.csr[B_TA] && !active) begin
      n.rem = n.transfer_byte_count;
      n.rel = 1'b0;
    end
    // DMA frame end overrides a software write
    if (dma_frame_end_i) begin
      n.csr[B_TA] = 1'b0;
    end

    // Shift engine
    if (s.busy) begin
      if (s.hcnt > 16'h1) begin
        n.hcnt = s.hcnt - 16'h1;
      end else begin
        n.hcnt = half;
        if (!s.ph) begin
          // Sample at the mid-bit edge
          n.rsh = {s.rsh[6:0], s.miso_sync[1]};
          n.ph  = 1'b1;
        end else begin
          n.ph = 1'b0;
          if (s.bitc == (low_speed_nine_bit_mode ? 4'h8 : 4'h7)) begin
            n.busy = 1'b0;
            rpush  = 1'b1;
            // Count exhausted: drop select when asked to
            if (dma_on && s.rem == 16'h0 && s.csr[B_AUTO_SELECT_RELEASE]) begin
              n.rel = 1'b1;
            end
          end else begin
            n.sh   = {s.sh[7:0], 1'b0};
            n.bitc = s.bitc + 4'h1;
          end
        end
      end
    end else if (active && s.tx_cnt != 5'h0 && !rx_full_flag
                 && !(dma_on && s.rem == 16'h0)) begin
      // Start only with room for the answer byte
      tpop   = 1'b1;
      n.busy = 1'b1;
      n.ph   = 1'b0;
      n.bitc = 4'h0;
      n.hcnt = half;
      // Ninth bit leads in low-speed mode
      n.sh   = low_speed_nine_bit_mode ? s.tx_mem[s.tx_rd]
                     : {s.tx_mem[s.tx_rd][7:0], 1'b0};
      if (dma_on) n.rem = s.rem - 16'h1;
    end

    // Abort on leaving the active state
    if (!n.csr[B_TA]) n.busy = 1'b0;

    // Clock level from next phase; idle level when quiet
    n.sclk = n.busy ? (n.csr[B_CPOL] ^ n.ph ^ n.csr[B_CPHA])
                    : n.csr[B_CPOL];

    // Transmit FIFO update
    for (int k = 0; k < 4; k++) begin
      if (k < int'(tpush)) begin
        // Single byte carries the ninth bit; words are parameters
        n.tx_mem[s.tx_wr + 4'(k)] = wide
          ? {1'b1, wb_i.dat[8*k +: 8]}
          : (k == 0 ? wb_i.dat[8:0] : 9'h0);
      end
    end
    n.tx_wr  = s.tx_wr + 4'(tpush);
    n.tx_rd  = s.tx_rd + 4'(tpop);
    n.tx_cnt = s.tx_cnt + 5'(tpush) - 5'(tpop);
    if (clr_tx) begin
      n.tx_wr  = 4'h0;
      n.tx_rd  = 4'h0;
      n.tx_cnt = 5'h0;
    end

    // Receive FIFO update
    if (rpush) n.rx_mem[s.rx_wr] = n.rsh;
    n.rx_wr  = s.rx_wr + 4'(rpush);
    n.rx_rd  = s.rx_rd + 4'(rpop);
    n.rx_cnt = s.rx_cnt + 5'(rpush) - 5'(rpop);
    if (clr_rx) begin
      n.rx_wr  = 4'h0;
      n.rx_rd  = 4'h0;
      n.rx_cnt = 5'h0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Bus answer
  assign wb_o = '{ack: s.ack, dat: s.rdat};

  // Serial data and clock from flops; read enable hands the
  // shared wire to the slave
  assign pins_o = '{sclk:    s.sclk,
                    mosi:    s.sh[8],
                    mosi_oe: ~(s.wire_shared & s.csr[B_REN]),
                    cs:      sel_lines};

  // Chip selects: only the chosen line asserts
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic act;
      logic pol;
      act = active & ~s.rel & (s.csr[1:0] == 2'(i));
      pol = s.csr[B_POL0 + i] | s.csr[B_SELECT_POLARITY_GLOBAL];
      sel_lines[i] = act ? pol : ~pol;
    end
  end

  // DMA requests from FIFO levels against thresholds; the transmit
  // side asks while inactive too, so the engine can load the header
  assign tx_dreq_o = dma_on
                   & ({3'h0, s.tx_cnt} <= s.dc[7:0]);
  assign rx_dreq_o = dma_on & (({3'h0, s.rx_cnt} > s.dc[23:16])
                   | (done & rxd));

  // Level interrupt while any enabled condition holds
  assign irq_o = (s.csr[B_RX_LEVEL_IRQ_ENABLE] & rx_needs_reading_flag)
               | (s.csr[B_DONE_IRQ_ENABLE] & done);

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_port_push;
    take && wb_i.we && wb_i.adr == OFF_FIFO && active
      && !dma_frame_end_i && s.tx_cnt == 5'h0 && !s.busy;
  endsequence
  sequence s_last_bit_end;
    s.busy && s.ph && s.hcnt <= 16'h1
      && s.bitc == (low_speed_nine_bit_mode ? 4'h8 : 4'h7);
  endsequence
  // Leading clock level of a byte
  sequence s_byte_start;
    !s.busy ##1 s.busy;
  endsequence

  a_full_stall: assert property (
    rx_full_flag && !s.busy && !take |=> !s.busy)
    else $error("shift started with receive FIFO full");
  a_tx_bound: assert property (
    s.tx_cnt <= FIFO_FULL && (txd || s.tx_cnt == FIFO_FULL))
    else $error("transmit level out of range");
  a_done_clear: assert property (
    s_port_push |=> !done)
    else $error("done stayed after port push");
  // Released lines sit at their inactive level
  a_auto_rel: assert property (
    s_last_bit_end and (dma_on && s.rem == 16'h0 && s.csr[B_AUTO_SELECT_RELEASE]
      && !dma_frame_end_i) |=> s.rel
      && pins_o.cs == ~{s.csr[23] | s.csr[B_SELECT_POLARITY_GLOBAL],
                        s.csr[22] | s.csr[B_SELECT_POLARITY_GLOBAL],
                        s.csr[21] | s.csr[B_SELECT_POLARITY_GLOBAL]})
    else $error("select not released at count end");
  a_no_dreq: assert property (
    !s.csr[B_DMA_REQUEST_ENABLE] |-> !tx_dreq_o && !rx_dreq_o)
    else $error("DMA request while disabled");
  a_frame_end: assert property (
    dma_frame_end_i |=> !active && !rx_needs_reading_flag && !done)
    else $error("frame end did not clear active");
  a_idle_clock: assert property (
    !s.busy |-> s.sclk == s.csr[B_CPOL])
    else $error("serial clock not at idle level");
  a_sel_none: assert property (
    s.csr[1:0] == SEL_NONE && !s.csr[B_SELECT_POLARITY_GLOBAL]
      && s.csr[23:21] == 3'h0 |-> pins_o.cs == 3'h7)
    else $error("reserved select code asserted a line");
  a_irq_off: assert property (
    !s.csr[B_RX_LEVEL_IRQ_ENABLE] && !s.csr[B_DONE_IRQ_ENABLE] |-> !irq_o)
    else $error("interrupt without enable");
  a_clear_tx: assert property (
    take && wb_i.we && wb_i.adr == OFF_CS && wb_i.sel[0]
      && wb_i.dat[B_CLRTX] |=> s.tx_cnt == 5'h0)
    else $error("transmit clear did not empty FIFO");
  a_first_edge: assert property (
    s_byte_start |-> s.sclk == (s.csr[B_CPOL] ^ s.csr[B_CPHA]))
    else $error("first clock transition misplaced");
  a_clear_rx: assert property (
    take && wb_i.we && wb_i.adr == OFF_CS && wb_i.sel[0]
      && wb_i.dat[B_CLRRX] |=> s.rx_cnt == 5'h0)
    else $error("receive clear did not empty FIFO");
endmodule
`default_nettype wire

// ### src/smc_pkg.sv
// Package: constants and types of the serial master control block
package smc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CS   = 8'h00;
  localparam logic [7:0] OFF_FIFO = 8'h04;
  localparam logic [7:0] OFF_CLK  = 8'h08;
  localparam logic [7:0] OFF_TRANSFER_BYTE_COUNT = 8'h0c;
  localparam logic [7:0] OFF_LOW_SPEED_HOLD_DELAY = 8'h10;
  localparam logic [7:0] OFF_DC   = 8'h14;
  localparam logic [7:0] OFF_WIRE = 8'h18; // Shared data wire mode
  // Control/status bit positions
  localparam int B_LONG  = 25;
  localparam int B_LDMA  = 24;
  localparam int B_POL0  = 21;
  localparam int B_RXF   = 20;
  localparam int B_RXR   = 19;
  localparam int B_TXD   = 18;
  localparam int B_RXD   = 17;
  localparam int B_DONE  = 16;
  localparam int B_LSM   = 13;
  localparam int B_REN   = 12;
  localparam int B_AUTO_SELECT_RELEASE  = 11;
  localparam int B_RX_LEVEL_IRQ_ENABLE  = 10;
  localparam int B_DONE_IRQ_ENABLE  = 9;
  localparam int B_DMA_REQUEST_ENABLE = 8;
  localparam int B_TA    = 7;
  localparam int B_SELECT_POLARITY_GLOBAL = 6;
  localparam int B_CLRRX = 5;
  localparam int B_CLRTX = 4;
  localparam int B_CPOL  = 3;
  localparam int B_CPHA  = 2;
  localparam int B_SEL   = 0;
  // Writable control bits and reset values
  localparam logic [25:0] CS_RW_MASK = 26'h3e0ffcf;
  localparam logic [25:0] CS_RST     = 26'h0001000;
  localparam logic [31:0] DC_RST     = 32'h30201020;
  localparam logic [3:0]  TOH_RST    = 4'h1;
  // FIFO geometry and levels
  localparam logic [4:0]  FIFO_FULL  = 5'h10;
  localparam logic [4:0]  RXR_LEVEL  = 5'h0c;
  localparam logic [2:0]  WORD_BYTES = 3'h4;
  localparam logic [15:0] HALF_MAX   = 16'h8000;
  localparam logic [1:0]  SEL_NONE   = 2'h3;

  // Wishbone request from master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } smc_wb_req_t;

  // Wishbone answer to master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } smc_wb_rsp_t;

  // Serial side pins
  typedef struct packed {
    logic       sclk;
    logic       mosi;
    logic       mosi_oe;
    logic [2:0] cs;
  } smc_pins_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0][8:0] tx_mem;
    logic [15:0][7:0] rx_mem;
    logic [3:0]       tx_rd;
    logic [3:0]       tx_wr;
    logic [4:0]       tx_cnt;
    logic [3:0]       rx_rd;
    logic [3:0]       rx_wr;
    logic [4:0]       rx_cnt;
    logic [25:0]      csr;
    logic [15:0]      divider_field;
    logic [15:0]      transfer_byte_count;
    logic [3:0]       output_hold_delay;
    logic [31:0]      dc;
    logic             wire_shared;
    logic             busy;
    logic             ph;
    logic [3:0]       bitc;
    logic [15:0]      hcnt;
    logic [8:0]       sh;
    logic [7:0]       rsh;
    logic             sclk;
    logic [15:0]      rem;
    logic             rel;
    logic             ack;
    logic [31:0]      rdat;
    logic [1:0]       miso_sync;
  } smc_state_t;

  localparam smc_state_t ST_RST = '{csr: CS_RST, dc: DC_RST,
                                     output_hold_delay: TOH_RST, default: '0};
endpackage

// ### dv/smc_slave.sv
// Serial slave model that captures data and answers with a fixed byte
`timescale 1ns/1ps
`default_nettype none
module smc_slave (
  // Serial pins seen from the slave
  input  wire logic        sclk_i,
  input  wire logic        sel_i,
  input  wire logic        mosi_i,
  // Bench control
  input  wire logic        clr_i,
  input  wire logic [7:0]  reply_i,
  // Slave answer and capture
  output logic             miso_o,
  output logic [31:0]      rx_o,
  output logic [7:0]       nbits_o
);
  logic [7:0] nsh;  // Falling edges seen while selected
  logic       bitv; // Reply bit now due

  // Capture on the rising edge, clock mode 0 only
  always @(posedge sclk_i or posedge clr_i) begin
    if (clr_i) begin
      rx_o    <= 32'h0;
      nbits_o <= 8'h0;
    end else if (sel_i) begin
      rx_o    <= {rx_o[30:0], mosi_i};
      nbits_o <= nbits_o + 8'h1;
    end
  end

  // Shift on the falling edge so the master sees a settled bit
  always @(negedge sclk_i or posedge clr_i) begin
    if (clr_i) begin
      nsh <= 8'h0;
    end else if (sel_i) begin
      nsh <= nsh + 8'h1;
    end
  end

  // Unselected, the line shows the inverse, never a stale level
  assign bitv   = reply_i[3'h7 - nsh[2:0]];
  assign miso_o = sel_i ? bitv : ~bitv;
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench of the serial master control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smc_pkg::*;
  logic        clk_i = 1'b0;     // 25 MHz clock
  logic        rst_i = 1'b1;     // Synchronous reset
  smc_wb_req_t wb_i  = '0;       // Bus request
  smc_wb_rsp_t wb_o;             // Bus answer
  smc_pins_t   pins_o;           // Serial pins
  logic        dma_frame_end_i = 1'b0; // Frame end pulse
  logic        tx_dreq_o;        // Transmit request
  logic        rx_dreq_o;        // Receive request
  logic        irq_o;            // Interrupt
  logic        miso;             // Slave data
  logic        clr   = 1'b1;     // Slave capture clear
  logic [31:0] s_rx;             // Slave capture
  logic [7:0]  s_nb;             // Slave bit count
  logic [31:0] rd;               // Last read data
  int          mismatches  = 0;
  int          checks_done = 0;

  // Clock, 40 ns period
  always #20 clk_i = ~clk_i;

  smc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .miso_i(miso), .pins_o(pins_o), .dma_frame_end_i(dma_frame_end_i),
    .tx_dreq_o(tx_dreq_o), .rx_dreq_o(rx_dreq_o), .irq_o(irq_o));

  // Slave counts as selected when any line leaves the idle pattern
  smc_slave slv (.sclk_i(pins_o.sclk), .sel_i(pins_o.cs != 3'h7),
    .mosi_i(pins_o.mosi), .clr_i(clr), .reply_i(8'h3c), .miso_o(miso),
    .rx_o(s_rx), .nbits_o(s_nb));

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack, the watchdog bounds it
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Poll a status bit, bounded by read count
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_CS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    if (rd[b] !== 1'b1) mismatches++;
  endtask

  task automatic slv_clr();
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask

  // Reset values, unmapped place, one-shot clear, wire turnaround
  task automatic t_reset();
    rdc(OFF_CS, 32'h00041000);
    rdc(OFF_DC, 32'h30201020);
    chk({28'h0, irq_o, pins_o.cs}, 32'h7);
    chk({30'h0, tx_dreq_o, rx_dreq_o}, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rdc(8'h1c, 32'h0);
    wr(OFF_WIRE, 32'h1);
    @(negedge clk_i);
    chk({31'h0, pins_o.mosi_oe}, 32'h0);
    wr(OFF_WIRE, 32'h0);
    wr(OFF_CS, 32'h00001030);
    rdc(OFF_CS, 32'h00041000);
    $display("t_reset done");
  endtask

  // One byte on line one with done interrupt
  task automatic t_byte();
    slv_clr();
    wr(OFF_CLK, 32'h8);
    wr(OFF_CS, 32'h00001281);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFF_FIFO, 32'h000000a5);
    @(negedge clk_i);
    chk({29'h0, pins_o.cs}, 32'h5);
    rdc(OFF_CS, 32'h00041281);
    wait_bit(B_DONE);
    chk(rd, 32'h00071281);
    chk(s_rx & 32'hff, 32'ha5);
    chk({24'h0, s_nb}, 32'h8);
    rdc(OFF_FIFO, 32'h3c);
    wr(OFF_CS, 32'h00001201);
    @(negedge clk_i);
    chk({28'h0, irq_o, pins_o.cs}, 32'h7);
    rdc(OFF_CS, 32'h00041201);
    $display("t_byte done");
  endtask

  // Select polarity, reserved code and idle clock level
  task automatic t_pol();
    wr(OFF_CS, 32'h0020008a);
    @(negedge clk_i);
    chk({28'h0, pins_o.sclk, pins_o.cs}, 32'ha);
    wr(OFF_CS, 32'h000000ca);
    @(negedge clk_i);
    chk({28'h0, pins_o.sclk, pins_o.cs}, 32'hc);
    wr(OFF_CS, 32'h000000cb);
    @(negedge clk_i);
    chk({28'h0, pins_o.sclk, pins_o.cs}, 32'h8);
    wr(OFF_CS, 32'h0000008b);
    @(negedge clk_i);
    chk({28'h0, pins_o.sclk, pins_o.cs}, 32'hf);
    wr(OFF_CS, 32'h0);
    @(negedge clk_i);
    chk({28'h0, pins_o.sclk, pins_o.cs}, 32'h7);
    $display("t_pol done");
  endtask

  // Clock phase one: first transition at the start of a bit
  task automatic t_phase();
    slv_clr();
    wr(OFF_CS, 32'h00000084);
    wr(OFF_FIFO, 32'h00000081);
    @(negedge clk_i);
    chk({31'h0, pins_o.sclk}, 32'h1);
    wait_bit(B_DONE);
    chk({24'h0, s_nb}, 32'h8);
    wr(OFF_CS, 32'h00000030);
    $display("t_phase done");
  endtask

  // Receive FIFO fills and stalls, transmit FIFO fills
  task automatic t_full();
    slv_clr();
    wr(OFF_CLK, 32'h2);
    wr(OFF_CS, 32'h00000430);
    wr(OFF_CS, 32'h00000480);
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wait_bit(B_RXF);
      wr(OFF_FIFO, 32'(i));
    end
    repeat (100) @(posedge clk_i);
    chk({24'h0, s_nb}, 32'h80);
    rdc(OFF_CS, 32'h001a0480);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFF_CS, 32'h00000400);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rdc(OFF_CS, 32'h00120400);
    wr(OFF_CS, 32'h00000030);
    rdc(OFF_CS, 32'h00040000);
    $display("t_full done");
  endtask

  // Preloaded length, word moves, auto release, frame end
  task automatic t_dma();
    slv_clr();
    wr(OFF_CLK, 32'h8);
    wr(OFF_CS, 32'h00000930);
    @(negedge clk_i);
    chk({30'h0, tx_dreq_o, rx_dreq_o}, 32'h2);
    wr(OFF_FIFO, 32'h00040080);
    rdc(OFF_TRANSFER_BYTE_COUNT, 32'h4);
    wr(OFF_FIFO, 32'h44332211);
    for (int n = 0; n < 1000 && pins_o.cs !== 3'h7; n++) @(posedge clk_i);
    chk(s_rx, 32'h11223344);
    chk({31'h0, rx_dreq_o}, 32'h1);
    rdc(OFF_FIFO, 32'h3c3c3c3c);
    dma_frame_end_i <= 1'b1;
    @(posedge clk_i);
    dma_frame_end_i <= 1'b0;
    rdc(OFF_CS, 32'h00040900);
    wr(OFF_CS, 32'h0);
    $display("t_dma done");
  endtask

  // Nine-bit item in low-speed mode
  task automatic t_low_speed_nine_bit_mode();
    slv_clr();
    wr(OFF_CS, 32'h00002080);
    wr(OFF_FIFO, 32'h000001a5);
    wait_bit(B_DONE);
    chk(s_rx & 32'h1ff, 32'h1a5);
    chk({24'h0, s_nb}, 32'h9);
    wr(OFF_CS, 32'h00000030);
    $display("t_low_speed_nine_bit_mode done");
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    clr   <= 1'b0;
    t_reset();
    t_byte();
    t_pol();
    t_phase();
    t_full();
    t_dma();
    t_low_speed_nine_bit_mode();
    results();
  end

  // Watchdog: tests need a few thousand cycles, allow 20000
  initial begin
    #800000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
